// file: include/fsc_pkg.sv
/*
 * Package of the fan speed controller: register map, configuration field
 * layout, timing constants and the channel phase encoding.
 * Assumes a 200 MHz core clock and a 32-bit APB with byte addresses.
 */
package fsc_pkg;
	localparam int NUM_CH = 2;
	localparam int APB_AW = 8;
	localparam int CLK_NS = 5;
	localparam int CLK_HZ = 200_000_000;
	// Speed timebase: one tick per microsecond.
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int PWM_FREQ_HZ = 25_000;
	localparam int PWM_STEPS = 256;
	localparam int PWM_CYC = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
	localparam logic [7:0] DIV_W = 8'h08;
	localparam logic [31:0] US_PER_MIN = 32'h0393_8700;
	localparam logic [23:0] STALL_TIMEOUT_US_DEF = 24'h07_A120;
	localparam logic [23:0] PERIOD_MAX = 24'hFF_FFFF;
	localparam logic [5:0] DIV_LAST = 6'h1F;
	// Register byte offsets.
	localparam logic [7:0] REG_CH_EN = 8'h00;
	localparam logic [7:0] REG_INT_STATUS = 8'h04;
	localparam logic [7:0] REG_INT_MASK = 8'h08;
	localparam logic [3:0] CH_BASE_HI = 4'h1;
	localparam logic [3:0] CH_CFG = 4'h0;
	localparam logic [3:0] CH_DUTY = 4'h4;
	localparam logic [3:0] CH_TARGET = 4'h8;
	localparam logic [3:0] CH_SPEED = 4'hC;
	// Configuration word fields.
	localparam int CFG_W = 13;
	localparam int CFG_AUTO = 0;
	localparam int CFG_STALL_AUTO_RESTART_OFF = 1;
	localparam int CFG_RAMP_FAST = 2;
	localparam int CFG_START_DUTY = 3;
	localparam int CFG_START_EDGES = 5;
	localparam int CFG_ADJUST_DELAY_PULSES = 7;
	localparam int CFG_SPEED_AVERAGE_SAMPLES = 9;
	localparam int CFG_PULSES_PER_REVOLUTION = 11;
	localparam logic [1:0] START_DUTY_OFF = 2'h0;
	// Duty runs 0..256 so that 256 is a steady high output.
	localparam int DUTY_W = 9;
	localparam logic [8:0] DUTY_MAX = 9'h100;
	localparam logic [8:0] DUTY_50 = 9'h080;
	localparam logic [8:0] DUTY_75 = 9'h0C0;
	localparam logic [8:0] RAMP_SLOW_STEP = 9'h001;
	localparam logic [8:0] RAMP_FAST_STEP = 9'h008;
	localparam logic [15:0] REACH_TOL_RPM = 16'h0020;
	// Event bits per channel inside status and mask.
	localparam int EV_STALL = 0;
	localparam int EV_REACH = 1;
	localparam int EV_PER_CH = 2;
	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_START = 4'b0010,
		PH_RUN = 4'b0100,
		PH_STOP = 4'b1000
	} fsc_phase_e;
endpackage

// file: rtl/fsc_top.sv
/*
 * Multi-channel cooling fan controller: APB register file, event status,
 * and one speed channel per fan with PWM output and tachometer input.
 * Assumes fans whose tachometer gives pulses asynchronous to core_clk.
 */
// What this block does
// - Channel stays idle and drives no PWM until software enables it.
// - Manual mode outputs exactly the software duty and still measures speed.
// - Automatic mode steers its own duty toward the software RPM target.
// - Target speed is held continuously without further software action.
// - Measured RPM is readable in both modes.
// - Duty readback gives written value in manual, computed value in automatic.
// - Events raised on fan stall and on reaching commanded speed.
// - Per-channel event enables, pending status view, software clear.
// - Automatic mode option restarts a stalled fan or leaves it stopped.
// - Automatic mode option selects fast or slow duty ramp.
// - Start duty is off, or fixed at 50, 75 or 100 percent.
// - Fixed start duty holds for a configured count of tachometer edges.
// - Automatic adjustments wait a configured count of tachometer pulses.
// - Speed is unaveraged or averaged over configured samples, both modes.
// - Pulses per revolution configurable per channel, used in RPM conversion.
// - Manual mode ignores restart, ramp, start-up and adjustment delay.
`timescale 1ns/1ps
module fsc_chan #(
	parameter logic [23:0] STALL_TIMEOUT_US = fsc_pkg::STALL_TIMEOUT_US_DEF
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic us_tick,
	input wire logic pwm_tick,
	input wire logic enable,
	input wire logic [fsc_pkg::CFG_W-1:0] cfg,
	input wire logic [fsc_pkg::DUTY_W-1:0] duty_man,
	input wire logic [15:0] target,
	input wire logic tach_in,
	output logic fan_pwm,
	output logic fan_pwm_oe,
	output logic [fsc_pkg::DUTY_W-1:0] duty_cur,
	output logic [15:0] speed,
	output logic stall_ev,
	output logic reach_ev
);
	import fsc_pkg::*;

	typedef struct packed {
		fsc_phase_e phase;
		logic [2:0] tach_sync;
		logic tach_lvl;
		logic have_ref;
		logic [23:0] period_cnt;
		logic [23:0] stall_cnt;
		logic [26:0] sum;
		logic [3:0] nsamp;
		logic [4:0] start_cnt;
		logic [3:0] adj_cnt;
		logic [8:0] duty_auto;
		logic div_busy;
		logic [5:0] div_cnt;
		logic [31:0] div_rem;
		logic [31:0] div_quo;
		logic [31:0] div_den;
		logic [15:0] speed;
		logic reached;
		logic [7:0] pwm_cnt;
		logic pwm;
		logic oe;
		logic [8:0] duty_cur;
		logic stall_ev;
		logic reach_ev;
	} fsc_chan_s;

	fsc_chan_s r_reg;
	fsc_chan_s r_next;

	always_comb begin
		logic auto_m;
		logic tach_edge;
		logic tach_rise;
		logic [8:0] sduty;
		logic [8:0] step;
		logic [8:0] duty_eff;
		logic [1:0] avg_k;
		logic [26:0] sum_all;
		logic [26:0] avg;
		logic [32:0] rem_sh;
		logic [31:0] quo_sh;
		logic reach_now;
		auto_m = cfg[CFG_AUTO];
		tach_edge = 1'b0;
		tach_rise = 1'b0;
		sduty = DUTY_MAX;
		step = cfg[CFG_RAMP_FAST] ? RAMP_FAST_STEP : RAMP_SLOW_STEP;
		duty_eff = '0;
		avg_k = cfg[CFG_SPEED_AVERAGE_SAMPLES +: 2];
		sum_all = '0;
		avg = '0;
		rem_sh = '0;
		quo_sh = '0;
		reach_now = 1'b0;
		r_next = r_reg;
		r_next.stall_ev = 1'b0;
		r_next.reach_ev = 1'b0;
		r_next.tach_sync = {r_reg.tach_sync[1:0], tach_in};
		// The edge counts only once the second and third stages agree.
		if (r_reg.tach_sync[1] == r_reg.tach_sync[2] && r_reg.tach_sync[1] != r_reg.tach_lvl) begin
			tach_edge = 1'b1;
			tach_rise = r_reg.tach_sync[1];
			r_next.tach_lvl = r_reg.tach_sync[1];
		end
		unique case (cfg[CFG_START_DUTY +: 2])
			2'h1: sduty = DUTY_50;
			2'h2: sduty = DUTY_75;
			default: sduty = DUTY_MAX;
		endcase
		if (!enable) begin
			// Clearing all state but the tachometer synchroniser also drops any half-done division or count.
			r_next = '0;
			r_next.phase = PH_IDLE;
			r_next.tach_sync = {r_reg.tach_sync[1:0], tach_in};
			r_next.tach_lvl = tach_edge ? r_reg.tach_sync[1] : r_reg.tach_lvl;
		end else begin
			if (!auto_m) begin
				duty_eff = duty_man;
			end else if (r_reg.phase == PH_START) begin
				duty_eff = sduty;
			end else if (r_reg.phase == PH_RUN) begin
				duty_eff = r_reg.duty_auto;
			end
			r_next.oe = 1'b1;
			r_next.duty_cur = duty_eff;
			if (pwm_tick) begin
				r_next.pwm_cnt = r_reg.pwm_cnt + 8'h01;
			end
			r_next.pwm = {1'b0, r_reg.pwm_cnt} < duty_eff;
			if (us_tick && r_reg.period_cnt != PERIOD_MAX) begin
				r_next.period_cnt = r_reg.period_cnt + 24'h00_0001;
			end
			if (tach_edge) begin
				r_next.stall_cnt = '0;
			end else if (us_tick && duty_eff != '0) begin
				r_next.stall_cnt = r_reg.stall_cnt + 24'h00_0001;
			end
			// Interval between rising edges, averaged over 1, 2, 4 or 8 samples.
			if (tach_rise) begin
				r_next.period_cnt = '0;
				r_next.have_ref = 1'b1;
				if (r_reg.have_ref) begin
					sum_all = r_reg.sum + {3'h0, r_reg.period_cnt};
					r_next.sum = sum_all;
					r_next.nsamp = r_reg.nsamp + 4'h1;
					if (r_reg.nsamp + 4'h1 >= (4'h1 << avg_k)) begin
						avg = sum_all >> avg_k;
						r_next.sum = '0;
						r_next.nsamp = '0;
						if (!r_reg.div_busy) begin
							r_next.div_busy = 1'b1;
							r_next.div_cnt = '0;
							r_next.div_rem = '0;
							r_next.div_quo = US_PER_MIN;
							r_next.div_den = 32'(avg) *
								(32'(cfg[CFG_PULSES_PER_REVOLUTION +: 2]) + 32'h1);
						end
					end
				end
			end
			// Restoring division, one quotient bit per cycle.
			if (r_reg.div_busy) begin
				rem_sh = {r_reg.div_rem, r_reg.div_quo[31]};
				quo_sh = {r_reg.div_quo[30:0], 1'b0};
				if (rem_sh >= {1'b0, r_reg.div_den}) begin
					rem_sh = rem_sh - {1'b0, r_reg.div_den};
					quo_sh[0] = 1'b1;
				end
				r_next.div_rem = rem_sh[31:0];
				r_next.div_quo = quo_sh;
				r_next.div_cnt = r_reg.div_cnt + 6'h01;
				if (r_reg.div_cnt == DIV_LAST) begin
					r_next.div_busy = 1'b0;
					r_next.speed = (quo_sh[31:16] != '0) ? 16'hFFFF : quo_sh[15:0];
				end
			end
			unique case (r_reg.phase)
				PH_IDLE: begin
					r_next.start_cnt = '0;
					r_next.adj_cnt = '0;
					if (auto_m && cfg[CFG_START_DUTY +: 2] != START_DUTY_OFF) begin
						r_next.phase = PH_START;
					end else begin
						r_next.phase = PH_RUN;
					end
				end
				PH_START: begin
					if (!auto_m) begin
						r_next.phase = PH_RUN;
					end else if (tach_edge) begin
						r_next.start_cnt = r_reg.start_cnt + 5'h01;
						if (r_reg.start_cnt + 5'h01 >= (5'h02 << cfg[CFG_START_EDGES +: 2])) begin
							r_next.phase = PH_RUN;
							r_next.duty_auto = sduty;
						end
					end
				end
				PH_RUN: begin
					if (auto_m && tach_rise) begin
						r_next.adj_cnt = r_reg.adj_cnt + 4'h1;
						if (r_reg.adj_cnt + 4'h1 >= (4'h1 << cfg[CFG_ADJUST_DELAY_PULSES +: 2])) begin
							r_next.adj_cnt = '0;
							if (r_reg.speed < target) begin
								r_next.duty_auto = (r_reg.duty_auto > DUTY_MAX - step) ?
									DUTY_MAX : r_reg.duty_auto + step;
							end else if (r_reg.speed > target) begin
								r_next.duty_auto = (r_reg.duty_auto < step) ?
									'0 : r_reg.duty_auto - step;
							end
						end
					end
				end
				PH_STOP: begin
					if (!auto_m) begin
						r_next.phase = PH_RUN;
					end
				end
			endcase
			if (r_reg.stall_cnt >= STALL_TIMEOUT_US && duty_eff != '0) begin
				r_next.stall_ev = 1'b1;
				r_next.stall_cnt = '0;
				r_next.speed = '0;
				r_next.have_ref = 1'b0;
				r_next.sum = '0;
				r_next.nsamp = '0;
				r_next.div_busy = 1'b0;
				r_next.start_cnt = '0;
				if (auto_m) begin
					if (cfg[CFG_STALL_AUTO_RESTART_OFF]) begin
						r_next.phase = PH_STOP;
					end else begin
						r_next.phase = PH_IDLE;
					end
				end
			end
			// One extra bit keeps the tolerance sums from wrapping near full scale.
			reach_now = auto_m && r_reg.phase == PH_RUN && target != '0 &&
				{1'b0, r_reg.speed} + {1'b0, REACH_TOL_RPM} >= {1'b0, target} &&
				{1'b0, r_reg.speed} <= {1'b0, target} + {1'b0, REACH_TOL_RPM};
			r_next.reached = reach_now;
			r_next.reach_ev = reach_now && !r_reg.reached;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			r_reg <= '0;
			r_reg.phase <= PH_IDLE;
			// The idle tachometer level is high, so no false edge follows reset.
			r_reg.tach_sync <= '1;
			r_reg.tach_lvl <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign fan_pwm = r_reg.pwm;
	assign fan_pwm_oe = r_reg.oe;
	assign duty_cur = r_reg.duty_cur;
	assign speed = r_reg.speed;
	assign stall_ev = r_reg.stall_ev;
	assign reach_ev = r_reg.reach_ev;
endmodule

module fsc_top #(
	parameter logic [23:0] STALL_TIMEOUT_US = fsc_pkg::STALL_TIMEOUT_US_DEF
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fsc_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [fsc_pkg::NUM_CH-1:0] fan_tach,
	output logic [fsc_pkg::NUM_CH-1:0] fan_pwm,
	output logic [fsc_pkg::NUM_CH-1:0] fan_pwm_oe,
	output logic irq
);
	import fsc_pkg::*;

	localparam int EV_W = NUM_CH * EV_PER_CH;

	typedef struct packed {
		logic [NUM_CH-1:0] ch_en;
		logic [NUM_CH-1:0][CFG_W-1:0] cfg;
		logic [NUM_CH-1:0][DUTY_W-1:0] duty_man;
		logic [NUM_CH-1:0][15:0] target;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic [31:0] prdata;
		logic pslverr;
		logic [7:0] us_div;
		logic [7:0] pwm_div;
		logic us_tick;
		logic pwm_tick;
	} fsc_top_s;

	fsc_top_s r_reg;
	fsc_top_s r_next;
	logic [NUM_CH-1:0][DUTY_W-1:0] duty_cur;
	logic [NUM_CH-1:0][15:0] speed;
	logic [EV_W-1:0] ev;

	genvar gc;
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
			fsc_chan #(.STALL_TIMEOUT_US(STALL_TIMEOUT_US)) u_chan (
				.core_clk(core_clk),
				.rstn(rstn),
				.us_tick(r_reg.us_tick),
				.pwm_tick(r_reg.pwm_tick),
				.enable(r_reg.ch_en[gc]),
				.cfg(r_reg.cfg[gc]),
				.duty_man(r_reg.duty_man[gc]),
				.target(r_reg.target[gc]),
				.tach_in(fan_tach[gc]),
				.fan_pwm(fan_pwm[gc]),
				.fan_pwm_oe(fan_pwm_oe[gc]),
				.duty_cur(duty_cur[gc]),
				.speed(speed[gc]),
				.stall_ev(ev[gc * EV_PER_CH + EV_STALL]),
				.reach_ev(ev[gc * EV_PER_CH + EV_REACH])
			);
		end
	endgenerate

	always_comb begin
		logic wr;
		logic hit;
		logic [EV_W-1:0] clr;
		wr = psel && penable && pwrite;
		hit = 1'b0;
		clr = '0;
		r_next = r_reg;
		r_next.us_tick = 1'b0;
		r_next.pwm_tick = 1'b0;
		r_next.us_div = r_reg.us_div + DIV_W'(1);
		if (r_reg.us_div == DIV_W'(TICK_CYC - 1)) begin
			r_next.us_div = '0;
			r_next.us_tick = 1'b1;
		end
		r_next.pwm_div = r_reg.pwm_div + DIV_W'(1);
		if (r_reg.pwm_div == DIV_W'(PWM_CYC - 1)) begin
			r_next.pwm_div = '0;
			r_next.pwm_tick = 1'b1;
		end
		// Read data and error are captured in the setup cycle, so access is zero-wait.
		if (psel && !penable) begin
			r_next.prdata = '0;
			unique case (paddr)
				REG_CH_EN: r_next.prdata[NUM_CH-1:0] = r_reg.ch_en;
				REG_INT_STATUS: r_next.prdata[EV_W-1:0] = r_reg.status;
				REG_INT_MASK: r_next.prdata[EV_W-1:0] = r_reg.mask;
				default: ;
			endcase
			hit = paddr == REG_CH_EN || paddr == REG_INT_STATUS || paddr == REG_INT_MASK;
			for (int c = 0; c < NUM_CH; c++) begin
				if (paddr[7:4] == CH_BASE_HI + 4'(c)) begin
					hit = 1'b1;
					unique case (paddr[3:0])
						CH_CFG: r_next.prdata[CFG_W-1:0] = r_reg.cfg[c];
						CH_DUTY: r_next.prdata[DUTY_W-1:0] = duty_cur[c];
						CH_TARGET: r_next.prdata[15:0] = r_reg.target[c];
						CH_SPEED: r_next.prdata[15:0] = speed[c];
						default: hit = 1'b0;
					endcase
				end
			end
			r_next.pslverr = !hit;
		end
		if (wr && !r_reg.pslverr) begin
			if (paddr == REG_CH_EN) begin
				r_next.ch_en = pwdata[NUM_CH-1:0];
			end
			if (paddr == REG_INT_STATUS) begin
				clr = pwdata[EV_W-1:0];
			end
			if (paddr == REG_INT_MASK) begin
				r_next.mask = pwdata[EV_W-1:0];
			end
			for (int c = 0; c < NUM_CH; c++) begin
				if (paddr[7:4] == CH_BASE_HI + 4'(c)) begin
					if (paddr[3:0] == CH_CFG) begin
						r_next.cfg[c] = pwdata[CFG_W-1:0];
					end
					if (paddr[3:0] == CH_DUTY) begin
						r_next.duty_man[c] = pwdata[DUTY_W-1:0];
					end
					if (paddr[3:0] == CH_TARGET) begin
						r_next.target[c] = pwdata[15:0];
					end
				end
			end
		end
		// A new event in the clearing cycle survives the clear.
		r_next.status = (r_reg.status & ~clr) | ev;
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata = r_reg.prdata;
	assign pready = psel && penable;
	assign pslverr = psel && penable && r_reg.pslverr;
	assign irq = |(r_reg.status & r_reg.mask);
endmodule

// file: testbench/fsc_fan_model.sv
/*
 * Behavioural cooling fan: spins at a fixed tachometer rate while its PWM
 * pin is driven and it is not told to stop.
 * Assumes an open-drain tachometer with a pull-up, so a stopped fan reads high.
 */
`timescale 1ns/1ps
module fsc_fan_model #(
	parameter int HALF_NS = 120000
) (
	input wire logic pwm_oe,
	input wire logic stop,
	output logic tach
);
	// The small offset keeps tachometer edges away from the clock edges.
	initial begin
		tach = 1'b1;
		#2;
		forever #(HALF_NS) tach = (pwm_oe && !stop) ? ~tach : 1'b1;
	end
endmodule

// file: testbench/fsc_top_sva.sv
/*
 * Port checker of the fan controller: APB answer, error response, idle
 * outputs and interrupt masking.
 * Assumes it is bound to fsc_top and sees only its ports.
 */
`timescale 1ns/1ps
module fsc_top_sva import fsc_pkg::*; #(
	parameter logic [23:0] STALL_TIMEOUT_US = STALL_TIMEOUT_US_DEF
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_CH-1:0] fan_tach,
	input wire logic [NUM_CH-1:0] fan_pwm,
	input wire logic [NUM_CH-1:0] fan_pwm_oe,
	input wire logic irq
);
	logic acc;
	logic en_wr;
	assign acc = psel && penable;
	assign en_wr = acc && pwrite && paddr == REG_CH_EN;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_ready; pready == acc; endproperty
	a_ready: assert property (p_ready) else $error("pready not equal to access phase");
	property p_err_acc; !acc |-> !pslverr; endproperty
	a_err_acc: assert property (p_err_acc) else $error("pslverr outside access");
	property p_unmapped; acc && (paddr == 8'h0C || paddr >= 8'h30) |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_err_data; pslverr && !pwrite |-> prdata == 32'h0; endproperty
	a_err_data: assert property (p_err_data) else $error("refused read returns data");
	property p_idle0; !fan_pwm_oe[0] |-> !fan_pwm[0]; endproperty
	a_idle0: assert property (p_idle0) else $error("pwm 0 high while undriven");
	property p_idle1; !fan_pwm_oe[1] |-> !fan_pwm[1]; endproperty
	a_idle1: assert property (p_idle1) else $error("pwm 1 high while undriven");
	// The pin must be released and stay released for the next cycle too, not just glitch low.
	property p_off; en_wr && !pwdata[0] |-> ##[1:3] !fan_pwm_oe[0] ##1 !fan_pwm_oe[0]; endproperty
	a_off: assert property (p_off) else $error("channel 0 still driven");
	property p_on; en_wr && pwdata[1] |-> ##[1:4] fan_pwm_oe[1]; endproperty
	a_on: assert property (p_on) else $error("channel 1 not driven");
	property p_mask; acc && pwrite && paddr == REG_INT_MASK && pwdata == 32'h0 |-> ##[1:3] !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("irq with all events masked");
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_off: cover property ($fell(fan_pwm_oe[0]));
endmodule

bind fsc_top fsc_top_sva #(.STALL_TIMEOUT_US(STALL_TIMEOUT_US)) fsc_top_sva_i (.core_clk, .rstn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fan_tach, .fan_pwm,
	.fan_pwm_oe, .irq);

// file: testbench/fsc_top_tb.sv
/*
 * Self-checking testbench of the fan controller: APB tasks, two fan models.
 * Assumes fans of 240 us tachometer period and four pulses per revolution.
 */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", nm, e, s); end end
module fsc_top_tb;
	import fsc_pkg::*;
	logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] fan_pwm, fan_pwm_oe, stop;
	wire logic [1:0] fan_tach;
	int num_errors = 0, cmp_count = 0, cyc = 0, hi;
	// Stall timeout just above the 120 us gap between tachometer edges keeps the run short.
	localparam logic [23:0] STALL_US = 24'h00_0096;
	localparam logic [7:0] RST_ADDR [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24};
	fsc_top #(.STALL_TIMEOUT_US(STALL_US)) fsc_top_i (.core_clk, .rstn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .fan_tach, .fan_pwm, .fan_pwm_oe, .irq);
	fsc_fan_model fsc_fan_model_i [1:0] (.pwm_oe(fan_pwm_oe), .stop(stop), .tach(fan_tach));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic summarize();
		$display("Comparisons %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// The stall events land near cycle 126000, so this ceiling leaves some margin.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 150000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdr(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		for (int i = 0; i < 3000; i++) begin
			rdr(a);
			if ((rd & m) === v)
				break;
			repeat (100) @(posedge core_clk);
		end
	endtask
	task automatic duty(input int ch, input int e);
		repeat (PWM_STEPS * PWM_CYC) @(posedge core_clk);
		hi = 0;
		repeat (PWM_STEPS * PWM_CYC) begin
			@(posedge core_clk);
			hi += fan_pwm[ch];
		end
		`CHK("pwm high time", 1'b1, hi >= (e - 1) * PWM_CYC && hi <= (e + 1) * PWM_CYC)
	endtask
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stop = 2'b00;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		foreach (RST_ADDR[i]) begin
			rdr(RST_ADDR[i]);
			`CHK("reset value", 32'h0, rd)
		end
		rdr(8'h0C);
		`CHK("unmapped error", 1'b1, er)
		`CHK("unmapped data", 32'h0, rd)
		// Manual channel carries start and ramp settings that it must ignore.
		wr(8'h10, 32'h0000_181C);
		wr(8'h14, 32'h0000_0080);
		wr(8'h20, 32'h0000_1815);
		wr(8'h28, 32'h0000_FFFF);
		`CHK("oe before enable", 2'b00, fan_pwm_oe)
		wr(8'h00, 32'h0000_0003);
		rdr(8'h14);
		`CHK("manual duty", 32'h80, rd)
		rdr(8'h24);
		`CHK("start duty", 32'hC0, rd)
		`CHK("oe enabled", 2'b11, fan_pwm_oe)
		duty(0, 128);
		wr(8'h14, 32'h0000_0100);
		duty(0, 256);
		wr(8'h14, 32'h0000_0080);
		poll(8'h1C, 32'hFFFF, 32'hF424);
		`CHK("manual speed", 32'hF424, rd)
		rdr(8'h2C);
		`CHK("auto speed", 32'hF424, rd)
		rdr(8'h24);
		`CHK("auto ramp", 1'b1, rd > 32'hC0 && rd <= 32'h100 && rd[2:0] == 3'h0)
		`CHK("auto step", 32'hC8, rd)
		wr(8'h08, 32'h0000_0009);
		wr(8'h28, 32'h0000_F424);
		poll(8'h04, 32'h8, 32'h8);
		`CHK("reach event", 32'h8, rd & 32'h8)
		`CHK("irq on reach", 1'b1, irq)
		wr(8'h04, 32'h0000_0008);
		rdr(8'h04);
		`CHK("reach cleared", 32'h0, rd & 32'h8)
		`CHK("irq cleared", 1'b0, irq)
		stop <= 2'b11;
		poll(8'h04, 32'h5, 32'h5);
		`CHK("stall events", 32'h5, rd & 32'hF)
		`CHK("irq on stall", 1'b1, irq)
		rdr(8'h1C);
		`CHK("stalled speed", 32'h0, rd)
		rdr(8'h14);
		`CHK("manual duty kept", 32'h80, rd)
		rdr(8'h24);
		`CHK("restart duty", 32'hC0, rd)
		wr(8'h08, 32'h0000_0000);
		repeat (2) @(posedge core_clk);
		`CHK("irq masked", 1'b0, irq)
		wr(8'h04, 32'h0000_000F);
		rdr(8'h04);
		`CHK("status cleared", 32'h0, rd & 32'h5)
		wr(8'h00, 32'h0000_0000);
		repeat (2) @(posedge core_clk);
		`CHK("oe disabled", 2'b00, fan_pwm_oe)
		`CHK("pwm disabled", 2'b00, fan_pwm)
		rdr(8'h24);
		`CHK("disabled duty", 32'h0, rd)
		summarize();
	end
endmodule
